// *** hw/csdb_data_break.sv ***
// Major state slice, memory registers and data break channel of a
// 12-bit processor, with an APB register slave.
// Assumes the processor supplies next state and next address each cycle
// and keeps its PC, AC and IR frozen while program_hold is high.
`timescale 1ns/1ns
// Behaviour
// - Timing pulse 1 samples request into sync
// - Timing pulse 4 starts break if sync
// - Load address; word count or break state
// - Break only at instruction end
// - Strobe address, 0.4 us accepted pulse
// - Overflow low from pulse 2, one cycle
// - Buffered break low in break state
// - Outward: memory word into buffer
// - Inward: buffer from peripheral, no read
// - Break cycle rechecks sync, else fetch
// - Program registers untouched, resume via fetch
// - Break replaces fetch; steal until dropped
// - Data out active high
// - Word count: increment, flag zero, advance
// - Current pointer: maybe increment, into address
module csdb_data_break #(
    parameter int WORD_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic break_request_n,
    input wire logic cycle_select,
    input wire logic transfer_direction,
    input wire logic pointer_advance_inhibit,
    input wire logic buffer_increment_n,
    input wire logic [WORD_W-1:0] address_n,
    input wire logic [WORD_W-1:0] data_in_n,
    output logic [WORD_W-1:0] data_out,
    output logic address_accepted_n,
    output logic tally_overflow_n,
    output logic buffered_break_n,
    input wire logic [2:0] instr_opcode,
    input wire logic instr_indirect,
    input wire logic [1:0] proc_next_state,
    input wire logic [WORD_W-1:0] proc_next_addr,
    output csdb_pkg::csdb_state_t major_state,
    output logic program_hold,
    output logic [WORD_W-1:0] mem_addr,
    output logic [WORD_W-1:0] mem_wdata,
    output logic mem_read,
    output logic mem_write,
    input wire logic [WORD_W-1:0] mem_rdata
);
    import csdb_pkg::*;

    if (WORD_W < 4 || WORD_W > 16) begin
        $error("WORD_W must lie between 4 and 16");
    end

    ////////////////////////////////////////////////////////////////////
    // Machine cycle timing
    logic [7:0] cyc_q;
    logic tp1;
    logic tp2;
    logic tp3;
    logic tp4;
    assign tp1 = (cyc_q == TP1_AT);
    assign tp2 = (cyc_q == TP2_AT);
    assign tp3 = (cyc_q == TP3_AT);
    assign tp4 = (cyc_q == TP4_AT);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_q <= 8'h00;
        end else if (tp4) begin
            cyc_q <= 8'h00;
        end else begin
            cyc_q <= cyc_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Break synchronizer and instruction end
    csdb_state_t state_q;
    logic break_sync_flag;
    logic ctrl_enable_q;
    logic in_steal;
    logic instr_end;
    logic take_break;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            break_sync_flag <= 1'b0;
        end else if (tp1) begin
            break_sync_flag <= ctrl_enable_q && !break_request_n;
        end
    end

    assign in_steal = state_q inside {CSDB_WORD_COUNT, CSDB_CURR_ADDR,
                                      CSDB_BREAK};

    always_comb begin
        instr_end = 1'b0;
        case (state_q)
            CSDB_FETCH: instr_end = (instr_opcode == OP_OPR) ||
                (instr_opcode == OP_IOT) ||
                (instr_opcode == OP_JMP && !instr_indirect);
            CSDB_DEFER: instr_end = (instr_opcode == OP_JMP);
            CSDB_EXECUTE: instr_end = (instr_opcode == OP_JMS) ||
                (instr_opcode == OP_DCA) || (instr_opcode == OP_ISZ) ||
                (instr_opcode == OP_TAD) || (instr_opcode == OP_AND);
            default: instr_end = 1'b0;
        endcase
    end

    assign take_break = tp4 && break_sync_flag &&
                        (instr_end || state_q == CSDB_BREAK);

    ////////////////////////////////////////////////////////////////////
    // Major state and memory address register
    logic [WORD_W-1:0] memory_address_register;
    logic [WORD_W-1:0] memory_buffer_register;
    csdb_state_t prog_next;

    always_comb begin
        case (proc_next_state)
            NEXT_DEFER: prog_next = CSDB_DEFER;
            NEXT_EXECUTE: prog_next = CSDB_EXECUTE;
            default: prog_next = CSDB_FETCH;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= CSDB_FETCH;
            memory_address_register <= '0;
        end else if (tp4) begin
            case (state_q)
                CSDB_WORD_COUNT: begin
                    memory_address_register <= memory_address_register + 1'b1;
                    state_q <= CSDB_CURR_ADDR;
                end
                CSDB_CURR_ADDR: begin
                    memory_address_register <= memory_buffer_register;
                    state_q <= CSDB_BREAK;
                end
                default: begin
                    if (take_break) begin
                        memory_address_register <= ~address_n;
                        state_q <= cycle_select ? CSDB_BREAK
                                                : CSDB_WORD_COUNT;
                    end else if (state_q == CSDB_BREAK) begin
                        // no new request, back to fetch
                        memory_address_register <= proc_next_addr;
                        state_q <= CSDB_FETCH;
                    end else begin
                        memory_address_register <= proc_next_addr;
                        state_q <= prog_next;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Memory buffer register and memory strobes
    logic incr_seen_q;
    logic [WORD_W-1:0] tally_next;
    logic outward;
    assign outward = !transfer_direction;
    assign tally_next = mem_rdata + 1'b1;
    // increment honoured only in outward break
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            incr_seen_q <= 1'b0;
        end else if (tp4) begin
            incr_seen_q <= 1'b0;
        end else if (state_q == CSDB_BREAK && outward &&
                     !buffer_increment_n) begin
            incr_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_read <= 1'b0;
        end else begin
            // no read strobe on inward transfer
            mem_read <= tp1 && in_steal &&
                        !(state_q == CSDB_BREAK && !outward);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            memory_buffer_register <= '0;
        end else if (tp2) begin
            case (state_q)
                CSDB_WORD_COUNT: memory_buffer_register <= tally_next;
                CSDB_CURR_ADDR: memory_buffer_register <=
                    pointer_advance_inhibit ? tally_next : mem_rdata;
                CSDB_BREAK: memory_buffer_register <=
                    outward ? mem_rdata : ~data_in_n;
                default: memory_buffer_register <= memory_buffer_register;
            endcase
        end else if (tp3 && incr_seen_q) begin
            memory_buffer_register <= memory_buffer_register + 1'b1;
        end
    end

    // Write one clock after the increment so the bumped word is stored
    logic write_due_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_due_q <= 1'b0;
            mem_write <= 1'b0;
            mem_wdata <= '0;
        end else begin
            write_due_q <= tp3 && in_steal;
            mem_write <= write_due_q;
            mem_wdata <= memory_buffer_register;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Peripheral indications
    logic [7:0] accept_cnt_q;
    logic [7:0] ovf_cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accept_cnt_q <= 8'h00;
            address_accepted_n <= 1'b1;
        end else if (take_break) begin
            accept_cnt_q <= 8'(ACCEPT_CLKS - 1);
            address_accepted_n <= 1'b0;
        end else if (accept_cnt_q != 8'h00) begin
            accept_cnt_q <= accept_cnt_q - 8'h01;
        end else begin
            address_accepted_n <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_cnt_q <= 8'h00;
            tally_overflow_n <= 1'b1;
        end else if (tp2 && state_q == CSDB_WORD_COUNT &&
                     tally_next == '0) begin
            ovf_cnt_q <= 8'(CYCLE_CLKS - 1);
            tally_overflow_n <= 1'b0;
        end else if (ovf_cnt_q != 8'h00) begin
            ovf_cnt_q <= ovf_cnt_q - 8'h01;
        end else begin
            tally_overflow_n <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buffered_break_n <= 1'b1;
            program_hold <= 1'b0;
        end else begin
            buffered_break_n <= !(state_q == CSDB_BREAK);
            program_hold <= in_steal;
        end
    end

    assign major_state = state_q;
    assign mem_addr = memory_address_register;
    assign data_out = memory_buffer_register;

    ////////////////////////////////////////////////////////////////////
    // APB slave
    logic [31:0] steal_count_q;
    logic access;
    logic wr_now;
    logic mapped;
    logic [31:0] rd_mux;

    assign access = psel && penable && !pready;
    assign wr_now = psel && penable && pready && pwrite && !pslverr;
    assign mapped = paddr inside {CTRL_OFF, STATUS_OFF, COUNT_OFF, REGS_OFF};

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            CTRL_OFF: rd_mux[CTRL_ENABLE_BIT] = ctrl_enable_q;
            STATUS_OFF: begin
                rd_mux[2:0] = state_q;
                rd_mux[STATUS_SYNC_BIT] = break_sync_flag;
                rd_mux[STATUS_OVF_BIT] = !tally_overflow_n;
                rd_mux[STATUS_HOLD_BIT] = in_steal;
            end
            COUNT_OFF: rd_mux = steal_count_q;
            REGS_OFF: begin
                rd_mux[WORD_W-1:0] = memory_address_register;
                rd_mux[REGS_MB_LSB +: WORD_W] = memory_buffer_register;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access && !mapped;
            if (access) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_enable_q <= CTRL_ENABLE_RST;
        end else if (wr_now && paddr == CTRL_OFF) begin
            ctrl_enable_q <= pwdata[CTRL_ENABLE_BIT];
        end
    end

    // A steal in the same cycle as a software clear is counted after the clear, leaving 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steal_count_q <= 32'h0000_0000;
        end else if (tp4 && (take_break || state_q == CSDB_WORD_COUNT ||
                             state_q == CSDB_CURR_ADDR)) begin
            steal_count_q <= (wr_now && paddr == COUNT_OFF) ?
                32'h0000_0001 : steal_count_q + 32'h0000_0001;
        end else if (wr_now && paddr == COUNT_OFF) begin
            steal_count_q <= 32'h0000_0000;
        end
    end

endmodule

// *** hw/csdb_pkg.sv ***
// Constants and types shared by the cycle-steal data break logic.
// Assumes a 100 MHz pclk and a 1.6 us machine cycle.
package csdb_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int MACHINE_CYCLE_NS = 1600;
    localparam int CYCLE_CLKS = MACHINE_CYCLE_NS / CLK_PERIOD_NS;

    // Timing pulse positions within one machine cycle, in clocks
    localparam logic [7:0] TP1_AT = 8'h28;
    localparam logic [7:0] TP2_AT = 8'h50;
    localparam logic [7:0] TP3_AT = 8'h78;
    localparam logic [7:0] TP4_AT = 8'h9F;

    // Address accepted pulse: 0.35 to 0.45 us
    localparam int ACCEPT_MIN_NS = 350;
    localparam int ACCEPT_MAX_NS = 450;
    localparam int ACCEPT_MIN_CLKS =
        (ACCEPT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCEPT_MAX_CLKS = ACCEPT_MAX_NS / CLK_PERIOD_NS;
    localparam int ACCEPT_CLKS = (ACCEPT_MIN_CLKS + ACCEPT_MAX_CLKS) / 2;

    // Request setup the peripheral owes before timing pulse 1
    localparam int REQ_SETUP_NS = 500;
    localparam int REQ_SETUP_CLKS =
        (REQ_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] COUNT_OFF = 8'h08;
    localparam logic [7:0] REGS_OFF = 8'h0C;

    // Field positions and reset values
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RST = 1'b1;
    localparam int STATUS_SYNC_BIT = 3;
    localparam int STATUS_OVF_BIT = 4;
    localparam int STATUS_HOLD_BIT = 5;
    localparam int REGS_MB_LSB = 16;

    // Instruction register opcodes
    localparam logic [2:0] OP_AND = 3'h0;
    localparam logic [2:0] OP_TAD = 3'h1;
    localparam logic [2:0] OP_ISZ = 3'h2;
    localparam logic [2:0] OP_DCA = 3'h3;
    localparam logic [2:0] OP_JMS = 3'h4;
    localparam logic [2:0] OP_JMP = 3'h5;
    localparam logic [2:0] OP_IOT = 3'h6;
    localparam logic [2:0] OP_OPR = 3'h7;

    typedef enum logic [2:0] {
        CSDB_FETCH = 3'h0,
        CSDB_DEFER = 3'h1,
        CSDB_EXECUTE = 3'h2,
        CSDB_WORD_COUNT = 3'h3,
        CSDB_CURR_ADDR = 3'h4,
        CSDB_BREAK = 3'h5
    } csdb_state_t;

    // Program next-state request from the processor
    localparam logic [1:0] NEXT_FETCH = 2'h0;
    localparam logic [1:0] NEXT_DEFER = 2'h1;
    localparam logic [1:0] NEXT_EXECUTE = 2'h2;

endpackage

// *** tb/csdb_data_break_props.sv ***
// Checker for the data break block, bound to its top-level ports.
// Assumes the machine cycle count restarts at zero on reset release.
`timescale 1ns/1ns
module csdb_data_break_props #(
    parameter int WORD_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic transfer_direction,
    input wire logic [WORD_W-1:0] address_n,
    input wire logic address_accepted_n,
    input wire logic tally_overflow_n,
    input wire logic buffered_break_n,
    input wire logic [2:0] instr_opcode,
    input wire logic instr_indirect,
    input wire csdb_pkg::csdb_state_t major_state,
    input wire logic program_hold,
    input wire logic [WORD_W-1:0] mem_addr,
    input wire logic mem_read
);
    import csdb_pkg::*;
    logic [7:0] ph_q;
    logic [7:0] acc_low_q;
    logic [7:0] ovf_low_q;

    // Mirror of the machine cycle, pulse 4 at the wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ph_q <= 8'h00;
        else
            ph_q <= (ph_q == TP4_AT) ? 8'h00 : ph_q + 8'h01;
    end
    // Low-time counters, so pulse widths are exact
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_low_q <= 8'h00;
            ovf_low_q <= 8'h00;
        end else begin
            acc_low_q <= address_accepted_n ? 8'h00 : acc_low_q + 8'h01;
            ovf_low_q <= tally_overflow_n ? 8'h00 : ovf_low_q + 8'h01;
        end
    end

    function automatic logic is_end(csdb_state_t s, logic [2:0] op,
                                    logic ind);
        case (s)
            CSDB_FETCH: return op >= OP_IOT || (op == OP_JMP && !ind);
            CSDB_DEFER: return op == OP_JMP;
            CSDB_EXECUTE: return op <= OP_JMS;
            default: return 1'b0;
        endcase
    endfunction

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_new_steal;
        $changed(major_state) && major_state inside
            {CSDB_WORD_COUNT, CSDB_BREAK};
    endsequence
    sequence s_addr_load;
        s_new_steal ##0 $past(major_state) != CSDB_CURR_ADDR;
    endsequence
    sequence s_enter_wc;
        $changed(major_state) && major_state == CSDB_WORD_COUNT;
    endsequence

    AST_STATE_AT_TP4: assert property (
        $changed(major_state) |-> ph_q == 8'h00)
        else $error("state changed off pulse 4");
    AST_ENTRY_AT_END: assert property (
        s_new_steal ##0 $past(major_state) < CSDB_WORD_COUNT |->
        is_end($past(major_state), $past(instr_opcode),
               $past(instr_indirect)))
        else $error("steal began inside an instruction");
    AST_MA_LOAD: assert property (
        s_addr_load |-> mem_addr == ~$past(address_n))
        else $error("address not loaded at steal start");
    AST_ACCEPT_START: assert property (
        s_addr_load |-> ##[0:1] !address_accepted_n)
        else $error("no address accepted pulse");
    AST_ACCEPT_WIDTH: assert property (
        $rose(address_accepted_n) |-> acc_low_q == ACCEPT_CLKS)
        else $error("address accepted pulse width wrong");
    AST_OVF_WIDTH: assert property (
        $rose(tally_overflow_n) |-> ovf_low_q == CYCLE_CLKS)
        else $error("overflow not one machine cycle");
    AST_BUF_BREAK: assert property (
        buffered_break_n == ($past(major_state) != CSDB_BREAK))
        else $error("buffered break does not follow state");
    AST_HOLD: assert property (
        program_hold == ($past(major_state) >= CSDB_WORD_COUNT))
        else $error("program hold does not follow steal");
    AST_WC_CHAIN: assert property (
        s_enter_wc |-> ##160 major_state == CSDB_CURR_ADDR
        ##160 major_state == CSDB_BREAK)
        else $error("three-cycle chain broken");
    AST_BREAK_EXIT: assert property (
        major_state == CSDB_BREAK && ph_q == TP4_AT |=> major_state inside
        {CSDB_FETCH, CSDB_WORD_COUNT, CSDB_BREAK})
        else $error("break left to a wrong state");
    AST_INWARD_NO_READ: assert property (
        major_state == CSDB_BREAK && transfer_direction |-> !mem_read)
        else $error("memory read in inward break");
endmodule

bind csdb_data_break csdb_data_break_props #(.WORD_W(WORD_W))
    u_csdb_data_break_props (
    .pclk, .presetn, .transfer_direction, .address_n, .address_accepted_n,
    .tally_overflow_n, .buffered_break_n, .instr_opcode, .instr_indirect,
    .major_state, .program_hold, .mem_addr, .mem_read
);

// *** tb/csdb_periph_model.sv ***
// Peripheral model on the break link: requests steals, shows lines.
// Assumes one-clock go pulses and a count of at least one.
`timescale 1ns/1ns
module csdb_periph_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [3:0] count,
    input wire logic [5:0] lag,
    input wire logic one_cycle,
    input wire logic inward,
    input wire logic adv,
    input wire logic bump,
    input wire logic [11:0] base_addr,
    input wire logic [11:0] base_data,
    input wire logic address_accepted_n,
    input wire logic buffered_break_n,
    output logic break_request_n,
    output logic cycle_select,
    output logic transfer_direction,
    output logic pointer_advance_inhibit,
    output logic buffer_increment_n,
    output logic [11:0] address_n,
    output logic [11:0] data_in_n,
    output logic busy
);
    logic [3:0] taken_q;
    logic [5:0] wait_q;
    logic acc_q;
    logic [11:0] addr_v;
    logic [11:0] data_v;

    assign addr_v = base_addr + {8'h00, taken_q};
    assign data_v = base_data + {8'h00, taken_q} - 12'h001;
    assign cycle_select = one_cycle;
    assign transfer_direction = inward;
    assign pointer_advance_inhibit = adv;
    // active low when valid; inverse once released
    assign address_n = busy ? ~addr_v : addr_v;
    assign data_in_n = (busy || !buffered_break_n) ? ~data_v : data_v;
    // increment only in an outward break
    assign buffer_increment_n = !(bump && !buffered_break_n && !inward);
    // request held until every steal taken
    assign break_request_n = !busy;

    // drop well before pulse 1; lag makes a slow device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            taken_q <= 4'h0;
            wait_q <= 6'h00;
            acc_q <= 1'b1;
        end else begin
            acc_q <= address_accepted_n;
            if (!busy) begin
                busy <= go;
                taken_q <= go ? 4'h0 : taken_q;
            end else if (acc_q && !address_accepted_n) begin
                taken_q <= taken_q + 4'h1;
                wait_q <= lag;
            end else if (wait_q != 6'h00)
                wait_q <= wait_q - 6'h01;
            else if (taken_q == count)
                busy <= 1'b0;
        end
    end
endmodule

// *** tb/csdb_data_break_tb.sv ***
// Bench for the data break block: APB registers and steal transfers.
// Assumes a flat memory array and a tiny processor stand-in here.
`timescale 1ns/1ns
module csdb_data_break_tb;
    import csdb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic break_request_n, cycle_select, transfer_direction;
    logic pointer_advance_inhibit, buffer_increment_n, address_accepted_n;
    logic tally_overflow_n, buffered_break_n, instr_indirect, program_hold;
    logic [11:0] address_n, data_in_n, data_out, proc_next_addr, mem_addr;
    logic [11:0] mem_wdata, mem_rdata, base_addr, base_data;
    logic [2:0] instr_opcode;
    logic [1:0] proc_next_state;
    logic mem_read, mem_write, go, one_cycle, inward, adv, bump, busy;
    logic [3:0] count;
    logic [5:0] lag;
    logic [11:0] mem [0:4095];
    csdb_state_t major_state, prev_state;
    int fails, checked, entries, ovf_clks, e0, n0;

    csdb_data_break u_csdb_data_break (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .break_request_n, .cycle_select, .transfer_direction,
        .pointer_advance_inhibit, .buffer_increment_n, .address_n,
        .data_in_n, .data_out, .address_accepted_n, .tally_overflow_n,
        .buffered_break_n, .instr_opcode, .instr_indirect, .proc_next_state,
        .proc_next_addr, .major_state, .program_hold, .mem_addr, .mem_wdata,
        .mem_read, .mem_write, .mem_rdata);
    csdb_periph_model u_csdb_periph_model (.pclk, .presetn, .go, .count,
        .lag, .one_cycle, .inward, .adv, .bump, .base_addr, .base_data,
        .address_accepted_n, .buffered_break_n, .break_request_n,
        .cycle_select, .transfer_direction, .pointer_advance_inhibit,
        .buffer_increment_n, .address_n, .data_in_n, .busy);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    assign mem_rdata = mem[mem_addr];
    // Memory, processor stand-in and event counters
    always @(posedge pclk) begin
        prev_state <= major_state;
        if (mem_write === 1'b1)
            mem[mem_addr] <= mem_wdata;
        if (tally_overflow_n === 1'b0)
            ovf_clks <= ovf_clks + 1;
        if (prev_state < CSDB_WORD_COUNT && major_state >= CSDB_WORD_COUNT)
            entries <= entries + 1;
        case (major_state)
            CSDB_FETCH: proc_next_state <= (instr_opcode >= OP_IOT ||
                (instr_opcode == OP_JMP && !instr_indirect)) ? NEXT_FETCH :
                instr_indirect ? NEXT_DEFER : NEXT_EXECUTE;
            CSDB_DEFER: proc_next_state <= (instr_opcode == OP_JMP) ?
                NEXT_FETCH : NEXT_EXECUTE;
            default: proc_next_state <= NEXT_FETCH;
        endcase
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic start(input logic o, input logic i, input logic [11:0] a,
        input logic [11:0] d, input logic [3:0] n, input logic p,
        input logic b);
        {one_cycle, inward, adv, bump} <= {o, i, p, b};
        base_addr <= a;
        base_data <= d;
        count <= n;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic finish;
        while (busy !== 1'b0 || major_state !== CSDB_FETCH)
            @(posedge pclk);
    endtask
    task automatic end_of_test;
        $display("checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, go, one_cycle, inward, adv} = '0;
        {bump, paddr, pwdata, count, lag, base_addr, base_data} = '0;
        {instr_opcode, instr_indirect} = {OP_OPR, 1'b0};
        proc_next_addr = 12'h100;
        proc_next_state = NEXT_FETCH;
        {fails, checked, entries, ovf_clks} = '0;
        foreach (mem[i])
            mem[i] = 12'h000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, CTRL_OFF, 32'h0);
        chk("enable", 32'h1, {31'h0, rd[CTRL_ENABLE_BIT]});
        apb(1'b0, 8'h10, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        mem[12'h123] = 12'hABC;
        start(1'b1, 1'b0, 12'h123, 12'h000, 4'h1, 1'b0, 1'b0);
        finish;
        chk("out data", 32'hABC, {20'h0, data_out});
        chk("restored", 32'hABC, {20'h0, mem[12'h123]});
        start(1'b1, 1'b0, 12'h123, 12'h000, 4'h1, 1'b0, 1'b1);
        finish;
        chk("bumped", 32'hABD, {20'h0, mem[12'h123]});
        apb(1'b1, COUNT_OFF, 32'h0);
        {mem[12'h040], mem[12'h041]} = {12'hFFF, 12'h200};
        n0 = ovf_clks;
        start(1'b0, 1'b1, 12'h040, 12'h777, 4'h1, 1'b1, 1'b0);
        finish;
        chk("tally", 32'h0, {20'h0, mem[12'h040]});
        chk("pointer", 32'h201, {20'h0, mem[12'h041]});
        chk("stored", 32'h777, {20'h0, mem[12'h201]});
        chk("ovf clocks", CYCLE_CLKS, ovf_clks - n0);
        apb(1'b0, COUNT_OFF, 32'h0);
        chk("steals", 32'h3, rd);
        mem[12'h040] = 12'hFFE;
        n0 = ovf_clks;
        start(1'b0, 1'b0, 12'h040, 12'h000, 4'h1, 1'b0, 1'b0);
        finish;
        chk("tally2", 32'hFFF, {20'h0, mem[12'h040]});
        chk("pointer2", 32'h201, {20'h0, mem[12'h041]});
        chk("out data2", 32'h777, {20'h0, data_out});
        chk("no ovf", 32'h0, ovf_clks - n0);
        lag <= 6'd20;
        e0 = entries;
        start(1'b1, 1'b1, 12'h300, 12'h0A0, 4'h3, 1'b0, 1'b0);
        finish;
        lag <= 6'd0;
        for (int i = 0; i < 3; i++)
            chk("block", 32'h0A0 + i, {20'h0, mem[12'h300 + i]});
        chk("entries", 32'h1, entries - e0);
        apb(1'b1, CTRL_OFF, 32'h0);
        start(1'b1, 1'b1, 12'h050, 12'h3C3, 4'h1, 1'b0, 1'b0);
        repeat (800) @(posedge pclk);
        chk("blocked", 32'h0, {20'h0, mem[12'h050]});
        apb(1'b1, CTRL_OFF, 32'h1);
        finish;
        chk("unblocked", 32'h3C3, {20'h0, mem[12'h050]});
        for (int i = 0; i < 16; i++) begin
            {instr_indirect, instr_opcode} <= 4'(i);
            start(1'b1, 1'b1, 12'h400 + 12'(i), 12'(i), 4'h1, 1'b0, 1'b0);
            finish;
            chk("op break", i, {20'h0, mem[12'h400 + i]});
        end
        end_of_test;
    end
    initial begin
        #700000;
        fails++;
        end_of_test;
    end
endmodule
